// File: design/fppc_float_cfg.sv
// Float pulse configuration registers, slot pulse sequencers and Wishbone slave.
//
// Register access over Wishbone was decided locally.
`timescale 1ns/1ns
// -------------------------------------------------------------
// -------------------------------------------------------------
module fppc_float_cfg (
    // Clock, reset and clock enable.
    input  wire logic                                ref_clk,
    input  wire logic                                resetn,
    input  wire logic                                ce,
    // Wishbone slave.
    input  wire logic                                wb_cyc_i,
    input  wire logic                                wb_stb_i,
    input  wire logic                                wb_we_i,
    input  wire logic [9:0]                          wb_adr_i,
    input  wire logic [3:0]                          wb_sel_i,
    input  wire logic [31:0]                         wb_dat_i,
    output logic      [31:0]                         wb_dat_o,
    output logic                                     wb_ack_o,
    // Slot sequencing.
    input  wire logic [1:0]                          slot_start,
    input  wire logic [1:0][7:0]                     slot_pulses,
    output logic      [1:0]                          slot_busy,
    output logic      [1:0]                          slot_done,
    // Samples and sums.
    input  wire logic [1:0]                          smp_valid,
    input  wire logic [1:0][fppc_pkg::SMP_W-1:0]     smp_data,
    output logic      [1:0][fppc_pkg::ACC_W-1:0]     slot_result,
    // LED drivers and analog setup.
    output logic      [2:0]                          led_drive,
    input  wire logic                                tia_adc_mode,
    output logic                                     int_as_buffer
);

    // -------------------------------------------------------------
    // State
    // -------------------------------------------------------------
    typedef struct packed {
        logic [fppc_pkg::NCFG-1:0][15:0] cfg;
        logic                            ack;
        logic [31:0]                     dat;
        logic                            intbuf;
        fppc_pkg::fppc_seq_t [1:0]       st;
        logic [1:0][7:0]                 cnt;
        logic [1:0][7:0]                 pdone;
        logic [1:0]                      done;
        logic [1:0][2:0]                 sled;
        logic [1:0][12:0]                ph;
    } fppc_top_state_t;

    localparam fppc_top_state_t RST_ST = '{
        cfg:     {fppc_pkg::RST_FIRE, fppc_pkg::RST_FLOAT_B, fppc_pkg::RST_MATH,
                  fppc_pkg::RST_LED, fppc_pkg::RST_LED},
        st:      '{fppc_pkg::S_IDLE, fppc_pkg::S_IDLE},
        default: '0
    };

    fppc_top_state_t               r, n;
    logic                          hit;
    logic [2:0]                    k;
    logic [31:0]                   rd;
    logic [1:0]                    tclr;
    logic [1:0]                    tick_w;
    logic [1:0]                    busy;
    logic [1:0][fppc_pkg::ACC_W-1:0] acc_w;
    logic [7:0]                    dl;
    logic [7:0]                    wd;
    logic [7:0]                    pc;
    logic [1:0]                    sel;
    logic [3:0]                    msk;
    logic                          fen_ok;
    logic                          last;
    logic [1:0][2:0]               sel_dec;
    logic [1:0]                    mbit;
    logic [2:0]                    fire;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);

    // -------------------------------------------------------------
    // Next state: register access and slot sequencers
    // -------------------------------------------------------------
    always_comb begin
        n      = r;
        hit    = 1'b0;
        k      = 3'h0;
        rd     = 32'h0000_0000;
        tclr   = 2'b00;
        dl     = 8'h00;
        wd     = 8'h00;
        pc     = 8'h00;
        sel    = 2'h0;
        msk    = 4'h0;
        fen_ok = 1'b0;
        last   = 1'b0;
        fire   = 3'h0;
        sel_dec = '0;
        mbit    = 2'b00;

        // Address decode of the configuration words.
        case (wb_adr_i[9:2])
            fppc_pkg::IDX_LED_A: begin
                hit = 1'b1;
                k   = 3'h0;
            end
            fppc_pkg::IDX_LED_B: begin
                hit = 1'b1;
                k   = 3'h1;
            end
            fppc_pkg::IDX_MATH: begin
                hit = 1'b1;
                k   = 3'h2;
            end
            fppc_pkg::IDX_FLOAT_B: begin
                hit = 1'b1;
                k   = 3'h3;
            end
            fppc_pkg::IDX_FIRE: begin
                hit = 1'b1;
                k   = 3'h4;
            end
            default: begin
                hit = 1'b0;
            end
        endcase

        // Read data; unmapped addresses read as zero.
        if (hit) begin
            rd = {16'h0000, r.cfg[k]};
        end else if (wb_adr_i[9:2] == fppc_pkg::IDX_STATUS) begin
            rd = {29'h0, r.intbuf, busy};
        end else if (wb_adr_i[9:2] == fppc_pkg::IDX_RES_A) begin
            rd = {{(32 - fppc_pkg::ACC_W){1'b0}}, acc_w[0]};
        end else if (wb_adr_i[9:2] == fppc_pkg::IDX_RES_B) begin
            rd = {{(32 - fppc_pkg::ACC_W){1'b0}}, acc_w[1]};
        end

        // One-cycle acknowledge; read data is captured with it.
        n.ack = wb_cyc_i && wb_stb_i && !r.ack;
        if (n.ack) begin
            n.dat = rd;
        end

        // Writes land on the edge that samples the acknowledge, per byte lane.
        if (r.ack && wb_cyc_i && wb_stb_i && wb_we_i && hit) begin
            for (int b = 0; b < 2; b++) begin
                if (wb_sel_i[b]) begin
                    n.cfg[k][b*8 +: 8] = wb_dat_i[b*8 +: 8];
                end
            end
        end

        // Integrator buffer only in TIA ADC mode.
        n.intbuf = r.cfg[2][fppc_pkg::INTBUF_BIT] && tia_adc_mode;

        // Per-slot pulse sequencer.
        for (int s = 0; s < 2; s++) begin
            dl  = r.cfg[s][fppc_pkg::DELAY_LSB +: 8];
            wd  = {3'h0, r.cfg[s][fppc_pkg::WIDTH_LSB +: 5]};
            pc  = {3'h0, r.cfg[3][fppc_pkg::PRECON_LSB +: 5]};
            sel = r.cfg[s][fppc_pkg::SEL_LSB +: 2];
            msk = r.cfg[4][(s == 0 ? fppc_pkg::FIREA_LSB : fppc_pkg::FIREB_LSB) +: 4];
            // Slot B starts only when its float enable is three.
            fen_ok = (s == 0) || (r.cfg[3][fppc_pkg::FEN_LSB +: 2] == fppc_pkg::FEN_ON);
            last   = (r.cnt[s] <= 8'h01);
            // Two-bit code to one driver line; code zero drives none.
            sel_dec[s] = (sel == 2'h0) ? 3'h0 : 3'(3'h1 << (sel - 2'h1));
            // Mask bit of the current group position.
            mbit[s] = msk[r.pdone[s][1:0]];
            fire    = mbit[s] ? 3'h0 : sel_dec[s];
            n.done[s] = 1'b0;
            if (tick_w[s] && !last) begin
                n.cnt[s] = r.cnt[s] - 8'h01;
            end
            case (r.st[s])
                fppc_pkg::S_IDLE: begin
                    if (slot_start[s] && fen_ok) begin
                        tclr[s]    = 1'b1;
                        n.pdone[s] = 8'h00;
                        if (s == 1) begin
                            n.st[s]  = fppc_pkg::S_PRECON;
                            n.cnt[s] = pc;
                        end else begin
                            n.st[s]  = fppc_pkg::S_DELAY;
                            n.cnt[s] = dl;
                        end
                    end
                end
                fppc_pkg::S_PRECON: begin
                    if (tick_w[s] && last) begin
                        n.st[s]  = fppc_pkg::S_DELAY;
                        n.cnt[s] = dl;
                    end
                end
                fppc_pkg::S_DELAY: begin
                    if (tick_w[s] && last) begin
                        n.st[s]   = fppc_pkg::S_PULSE;
                        n.cnt[s]  = wd;
                        n.sled[s] = fire;
                    end
                end
                fppc_pkg::S_PULSE: begin
                    // Pulse lasts its width in microseconds.
                    if (tick_w[s] && last) begin
                        n.sled[s]  = 3'h0;
                        n.pdone[s] = r.pdone[s] + 8'h01;
                        if (r.pdone[s] + 8'h01 >= slot_pulses[s]) begin
                            n.st[s]   = fppc_pkg::S_IDLE;
                            n.done[s] = 1'b1;
                        end else begin
                            n.st[s]  = fppc_pkg::S_GAP;
                            n.cnt[s] = fppc_pkg::GAP_US;
                        end
                    end
                end
                fppc_pkg::S_GAP: begin
                    if (tick_w[s] && last) begin
                        n.st[s]   = fppc_pkg::S_PULSE;
                        n.cnt[s]  = wd;
                        n.sled[s] = fire;
                    end
                end
                default: begin
                    n.st[s]   = fppc_pkg::S_IDLE;
                    n.sled[s] = 3'h0;
                end
            endcase
            // Enabled cycles spent in the current phase.
            n.ph[s] = (n.st[s] != r.st[s]) ? 13'h0000 : 13'(r.ph[s] + 13'h0001);
        end
    end

    // State register; a low clock enable freezes everything.
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            r <= RST_ST;
        end else if (ce) begin
            r <= n;
        end
    end

    // Outputs from flip-flops; led_drive ORs both slots and slot_busy decodes the state.
    assign wb_ack_o      = r.ack;
    assign wb_dat_o      = r.dat;
    assign slot_done     = r.done;
    assign slot_busy     = busy;
    assign slot_result   = acc_w;
    assign int_as_buffer = r.intbuf;
    assign led_drive     = r.sled[0] | r.sled[1];

    // -------------------------------------------------------------
    // Per-slot tick and sample math
    // -------------------------------------------------------------
    for (genvar g = 0; g < 2; g++) begin : g_slot
        fppc_math_if mif ();
        logic [12:0] dly_cyc;
        logic [12:0] wid_cyc;

        assign busy[g] = (r.st[g] != fppc_pkg::S_IDLE);

        assign mif.clear     = tclr[g] && ce;
        assign mif.smp_valid = smp_valid[g];
        assign mif.smp       = smp_data[g];
        assign mif.early_op  =
            r.cfg[2][(g == 0 ? fppc_pkg::M12A_LSB : fppc_pkg::M12B_LSB) +: 2];
        assign mif.late_op   =
            r.cfg[2][(g == 0 ? fppc_pkg::M34A_LSB : fppc_pkg::M34B_LSB) +: 2];
        assign acc_w[g]      = mif.acc;

        fppc_tick #(.DIV(fppc_pkg::STEP_CYC)) u_tick (
            .ref_clk (ref_clk),
            .resetn  (resetn),
            .ce      (ce),
            .clear   (tclr[g]),
            .tick    (tick_w[g])
        );

        fppc_sample_math u_math (
            .ref_clk (ref_clk),
            .resetn  (resetn),
            .ce      (ce),
            .m       (mif.math)
        );

        // Expected phase lengths in enabled cycles, zero counting as one step.
        assign dly_cyc = 13'((r.cfg[g][7:0] == 8'h00 ? 1 : int'(r.cfg[g][7:0]))
                             * fppc_pkg::STEP_CYC - 1);
        assign wid_cyc = 13'((r.cfg[g][12:8] == 5'h00 ? 1 : int'(r.cfg[g][12:8]))
                             * fppc_pkg::STEP_CYC - 1);

        // Delay to first pulse in microseconds.
        chk_delay_len: assert property (
            ce && r.st[g] == fppc_pkg::S_DELAY && n.st[g] == fppc_pkg::S_PULSE
            |-> r.ph[g] == dly_cyc)
            else $error("Delay to first pulse has wrong length.");

        chk_pulse_len: assert property (
            ce && r.st[g] == fppc_pkg::S_PULSE && n.st[g] != fppc_pkg::S_PULSE
            |-> r.ph[g] == wid_cyc)
            else $error("LED pulse has wrong width.");

        // Unmasked pulse drives the selected driver.
        chk_led_select: assert property (
            ce && r.st[g] != fppc_pkg::S_PULSE && n.st[g] == fppc_pkg::S_PULSE && !mbit[g]
            |=> r.sled[g] == $past(sel_dec[g]))
            else $error("LED driver does not match selection.");

        // Masked pulse position fires no LED.
        chk_mask_skip: assert property (
            ce && r.st[g] != fppc_pkg::S_PULSE && n.st[g] == fppc_pkg::S_PULSE && mbit[g]
            |=> r.sled[g] == 3'h0 ##1 r.sled[g] == 3'h0 || r.st[g] != fppc_pkg::S_PULSE)
            else $error("Masked pulse fired an LED.");

        if (g == 1) begin : g_b
            // Slot B stays idle unless float enable is three.
            chk_float_gate: assert property (
                ce && r.st[g] == fppc_pkg::S_IDLE && slot_start[g]
                && r.cfg[3][fppc_pkg::FEN_LSB +: 2] != fppc_pkg::FEN_ON
                |=> r.st[g] == fppc_pkg::S_IDLE)
                else $error("Slot B ran with float mode disabled.");

            chk_precon_len: assert property (
                ce && r.st[g] == fppc_pkg::S_PRECON && n.st[g] == fppc_pkg::S_DELAY
                |-> r.ph[g] == 13'((r.cfg[3][12:8] == 5'h00 ? 1 : int'(r.cfg[3][12:8]))
                                   * fppc_pkg::STEP_CYC - 1))
                else $error("Preconditioning time has wrong length.");
        end
    end

    // Buffer output stays off while its bit is clear.
    chk_int_buf: assert property (
        ce && !r.cfg[2][fppc_pkg::INTBUF_BIT] ##1 ce |-> !int_as_buffer ##1 1'b1)
        else $error("Integrator buffer enabled without its bit.");

endmodule

// File: design/fppc_pkg.sv
// Package with register map, field layout, reset values and timing of the float pulse block.
package fppc_pkg;

    // -------------------------------------------------------------
    // Register indexes; the byte address is four times the index.
    // -------------------------------------------------------------
    localparam logic [7:0] IDX_LED_A   = 8'h3E;
    localparam logic [7:0] IDX_LED_B   = 8'h3F;
    localparam logic [7:0] IDX_MATH    = 8'h58;
    localparam logic [7:0] IDX_FLOAT_B = 8'h59;
    localparam logic [7:0] IDX_FIRE    = 8'h5A;
    localparam logic [7:0] IDX_STATUS  = 8'h60;
    localparam logic [7:0] IDX_RES_A   = 8'h61;
    localparam logic [7:0] IDX_RES_B   = 8'h62;
    localparam int         NCFG        = 5;

    // -------------------------------------------------------------
    // Field positions (low bit of each field).
    // -------------------------------------------------------------
    localparam int SEL_LSB    = 14;
    localparam int WIDTH_LSB  = 8;
    localparam int DELAY_LSB  = 0;
    localparam int M34B_LSB   = 10;
    localparam int M34A_LSB   = 8;
    localparam int INTBUF_BIT = 7;
    localparam int M12B_LSB   = 5;
    localparam int M12A_LSB   = 1;
    localparam int FEN_LSB    = 13;
    localparam int PRECON_LSB = 8;
    localparam int FIREB_LSB  = 12;
    localparam int FIREA_LSB  = 8;

    // -------------------------------------------------------------
    // Reset values and codes.
    // -------------------------------------------------------------
    localparam logic [15:0] RST_LED     = 16'h0320;
    localparam logic [15:0] RST_MATH    = 16'h0000;
    localparam logic [15:0] RST_FLOAT_B = 16'h0808;
    localparam logic [15:0] RST_FIRE    = 16'h0000;
    localparam logic [1:0]  FEN_ON      = 2'h3;

    // -------------------------------------------------------------
    // Timing and data widths.
    // -------------------------------------------------------------
    localparam int         CLK_NS   = 50;
    localparam int         STEP_NS  = 1000;
    localparam int         STEP_CYC = STEP_NS / CLK_NS;
    localparam logic [7:0] GAP_US   = 8'h01;
    localparam int         SMP_W    = 14;
    localparam int         ACC_W    = 20;

    // Slot sequencer states.
    typedef enum logic [4:0] {
        S_IDLE   = 5'h01,
        S_PRECON = 5'h02,
        S_DELAY  = 5'h04,
        S_PULSE  = 5'h08,
        S_GAP    = 5'h10
    } fppc_seq_t;

endpackage

// File: design/fppc_math_if.sv
// Interface between a slot sequencer and its sample math unit.
`timescale 1ns/1ns
interface fppc_math_if;
    // Control from the slot sequencer.
    logic                              clear;
    logic                              smp_valid;
    logic signed [fppc_pkg::SMP_W-1:0] smp;
    logic        [1:0]                 early_op;
    logic        [1:0]                 late_op;
    // State of the math unit.
    logic        [1:0]                 idx;
    logic signed [fppc_pkg::ACC_W-1:0] acc;

    modport ctrl (output clear, smp_valid, smp, early_op, late_op, input idx, acc);
    modport math (input clear, smp_valid, smp, early_op, late_op, output idx, acc);
endinterface

// File: design/fppc_tick.sv
// Microsecond tick generator with a phase restart.
`timescale 1ns/1ns
module fppc_tick #(
    parameter int DIV = 20
) (
    // Clock, reset and clock enable.
    input  wire logic ref_clk,
    input  wire logic resetn,
    input  wire logic ce,
    // Restart and tick.
    input  wire logic clear,
    output logic      tick
);
    localparam int CW = $clog2(DIV);

    typedef struct packed {
        logic [CW-1:0] cnt;
    } fppc_tick_state_t;

    fppc_tick_state_t r, n;

    // One tick every DIV enabled cycles after a restart.
    assign tick = ce && !clear && (r.cnt == CW'(DIV - 1));

    // Next count.
    always_comb begin
        n = r;
        if (clear || tick) begin
            n.cnt = '0;
        end else begin
            n.cnt = CW'(r.cnt + 1'b1);
        end
    end

    // State register.
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            r <= '0;
        end else if (ce) begin
            r <= n;
        end
    end
endmodule

// File: design/fppc_sample_math.sv
// Add and subtract unit for the samples of each four-pulse group.
`timescale 1ns/1ns
module fppc_sample_math (
    // Clock, reset and clock enable.
    input  wire logic  ref_clk,
    input  wire logic  resetn,
    input  wire logic  ce,
    // Link to the slot sequencer.
    fppc_math_if.math  m
);
    typedef struct packed {
        logic        [1:0]                 idx;
        logic signed [fppc_pkg::ACC_W-1:0] acc;
    } fppc_math_state_t;

    fppc_math_state_t                  r, n;
    logic signed [fppc_pkg::ACC_W-1:0] sext;
    logic                              neg;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);

    // Sign-extended sample and its sign from the pair code of its group position.
    assign sext = fppc_pkg::ACC_W'(m.smp);
    assign neg  = r.idx[1] ? (r.idx[0] ? m.late_op[0] : m.late_op[1])
                           : (r.idx[0] ? m.early_op[0] : m.early_op[1]);

    // Group position wraps every four samples.
    always_comb begin
        n = r;
        if (m.clear) begin
            n.idx = 2'h0;
            n.acc = '0;
        end else if (m.smp_valid) begin
            n.idx = r.idx + 2'h1;
            n.acc = neg ? r.acc - sext : r.acc + sext;
        end
    end

    // State register.
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            r <= '0;
        end else if (ce) begin
            r <= n;
        end
    end

    assign m.idx = r.idx;
    assign m.acc = r.acc;

    // Fifth sample starts a new group.
    chk_group_wrap: assert property (
        ce && m.smp_valid && !m.clear && r.idx == 2'h3 |=> r.idx == 2'h0)
        else $error("Group position did not wrap after the fourth sample.");

    // First sample subtracted when the early code asks.
    chk_early_sign: assert property (
        ce && m.smp_valid && !m.clear && r.idx == 2'h0 && m.early_op[1]
        |=> r.acc == $past(r.acc) - $past(sext))
        else $error("First sample of a group was not subtracted.");

    // Fourth sample added when the late code does not ask to subtract.
    chk_late_sign: assert property (
        ce && m.smp_valid && !m.clear && r.idx == 2'h3 && !m.late_op[0]
        |=> r.acc == $past(r.acc) + $past(sext))
        else $error("Fourth sample of a group was not added.");
endmodule

// File: tb/float_mode_led_pulse_config_bench.sv
// Self-checking bench for the float pulse configuration block.
`timescale 1ns/1ns
module float_mode_led_pulse_config_bench;
    logic                   ref_clk = 1'b0;
    logic                   resetn  = 1'b0;
    logic                   cyc = 1'b0, stb = 1'b0, we = 1'b0, tia = 1'b0, ack, ibuf;
    logic [9:0]             adr = 10'h000;
    logic [31:0]            dat = 32'h00000000, dat_o, q;
    logic [1:0]             start = 2'h0, sv = 2'h0, busy, done;
    logic [1:0][7:0]        np = 16'h0808;
    logic [1:0][13:0]       sd = 28'h0000000;
    logic [1:0][19:0]       res;
    logic [2:0]             led;
    logic [7:0]             idx;
    logic [15:0]            w, m;
    logic signed [13:0]     a;
    logic signed [19:0]     ex [2];
    int                     n_fail = 0, check_count = 0, cyc_n = 0, n, t, seed = 32'haeeb97ed;
    always #25 ref_clk = ~ref_clk;
    fppc_float_cfg u_dut (.ref_clk(ref_clk), .resetn(resetn), .ce(1'b1), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h3), .wb_dat_i(dat),
        .wb_dat_o(dat_o), .wb_ack_o(ack), .slot_start(start), .slot_pulses(np),
        .slot_busy(busy), .slot_done(done), .smp_valid(sv), .smp_data(sd),
        .slot_result(res), .led_drive(led), .tia_adc_mode(tia), .int_as_buffer(ibuf));
    // Compares one value and reports a mismatch.
    task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // One classic Wishbone cycle; read data lands in q.
    task wb(input logic wr, input logic [7:0] i, input logic [15:0] d);
        @(posedge ref_clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we  <= wr;
        adr <= {i, 2'h0};
        dat <= {16'h0000, d};
        // Request stands until the rising edge that samples ack high.
        do @(posedge ref_clk); while (ack !== 1'b1);
        q = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    task pulse_start(input logic [1:0] s);
        @(posedge ref_clk);
        start <= s;
        @(posedge ref_clk);
        start <= 2'h0;
    endtask
    // Negate flag of a sample position for slot s under math word c.
    function automatic logic ng(input int p, input int s, input logic [15:0] c);
        logic [3:0] b;
        b = s ? {c[10], c[11], c[5], c[6]} : {c[8], c[9], c[1], c[2]};
        return b[p];
    endfunction
    task tally_and_finish;
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    always @(posedge ref_clk) begin
        cyc_n++;
        if (cyc_n == 5000) begin
            n_fail++;
            tally_and_finish;
        end
    end
    initial begin
        repeat (6) @(posedge ref_clk);
        resetn <= 1'b1;
        wb(0, 8'h3E, 0);
        check("rst_a", q, 32'h0320);
        wb(0, 8'h3F, 0);
        check("rst_b", q, 32'h0320);
        wb(0, 8'h58, 0);
        check("rst_math", q, 0);
        wb(0, 8'h59, 0);
        check("rst_float", q, 32'h0808);
        wb(0, 8'h20, 0);
        check("unmapped", q, 0);
        // Random write and read-back, reserved bits kept at zero.
        for (int k = 0; k < 12; k++) begin
            t = $random(seed);
            idx = (t[1:0] == 2'h0) ? 8'h3E : (t[0] ? 8'h3F : 8'h58);
            w = $random(seed);
            w = w & ((idx == 8'h58) ? 16'hFFE7 : 16'hDFFF);
            wb(1, idx, w);
            wb(0, idx, 0);
            check("readback", q, {16'h0000, w});
        end
        wb(1, 8'h59, 16'h2808);
        pulse_start(2'h2);
        @(negedge ref_clk);
        check("b_refused", busy, 2'h0);
        m = $random(seed);
        m = m & 16'h0F66;
        wb(1, 8'h58, m);
        wb(1, 8'h59, 16'h6108);
        wb(1, 8'h3E, 16'h8101);
        pulse_start(2'h3);
        n = 0;
        do begin
            @(negedge ref_clk);
            n++;
        end while (led === 3'h0 && n < 60);
        check("b_busy", busy, 2'h3);
        check("led_sel", led, 3'h2);
        check("delay_ok", (n >= 21 && n <= 23), 1);
        ex[0] = 0;
        ex[1] = 0;
        for (int k = 0; k < 8; k++) begin
            @(posedge ref_clk);
            sv <= 2'h3;
            for (int s = 0; s < 2; s++) begin
                a = $random(seed);
                sd[s] <= a;
                ex[s] = ng(k % 4, s, m) ? ex[s] - a : ex[s] + a;
            end
        end
        @(posedge ref_clk);
        sv <= 2'h0;
        repeat (2) @(negedge ref_clk);
        check("sum_a", res[0], {12'h000, ex[0]});
        check("sum_b", res[1], {12'h000, ex[1]});
        // Slot A ends after its eight pulses with a one-cycle done.
        n = 0;
        do begin
            @(negedge ref_clk);
            n++;
        end while (done[0] !== 1'b1 && n < 400);
        check("done_a", done[0], 1);
        wb(1, 8'h58, 16'h0080);
        @(posedge ref_clk);
        tia <= 1'b1;
        repeat (3) @(negedge ref_clk);
        check("buf_on", ibuf, 1);
        @(posedge ref_clk);
        tia <= 1'b0;
        repeat (3) @(negedge ref_clk);
        check("buf_off", ibuf, 0);
        // Mode high but the bit clear keeps the buffer off.
        wb(1, 8'h58, 16'h0000);
        @(posedge ref_clk);
        tia <= 1'b1;
        repeat (3) @(negedge ref_clk);
        check("buf_bit_clear", ibuf, 0);
        tally_and_finish;
    end
endmodule
